//--- pci_sec_pkg.sv
//----------------------------------------------------------------------
// Purpose : Shared constants and types for one secondary parallel bus
// Assumes : 32-bit multiplexed bus, one clock per bus
// Notes   : Control lines are carried as one active-low vector
//----------------------------------------------------------------------
package pci_sec_pkg;
	localparam int AD_W                = 32;
	localparam int CBE_W               = 4;
	localparam int CTL_W               = 7;
	localparam int NREQ_BUS_A          = 8;
	localparam int NREQ_BUS_B          = 7;
	localparam int FIFO_DEPTH          = 16;
	localparam int MASTER_ABORT_CYCLES = 5;
	localparam int GNT_GAP_CYCLES      = 2;

	// Bit positions in the control vector
	localparam int C_FRAME  = 0;
	localparam int C_IRDY   = 1;
	localparam int C_TRDY   = 2;
	localparam int C_DEVSEL = 3;
	localparam int C_STOP   = 4;
	localparam int C_LOCK   = 5;
	localparam int C_PERR   = 6;

	localparam logic [2:0]       ABORT_CNT        = 3'(MASTER_ABORT_CYCLES);
	localparam logic [1:0]       GAP_LOAD         = 2'(GNT_GAP_CYCLES - 1);
	localparam logic [CBE_W-1:0] CMD_MEM_WRITE    = 4'h7;
	localparam logic [CBE_W-1:0] BE_ALL           = 4'h0;
	localparam logic [AD_W-1:0]  DEV_ADDR_BASE    = 32'h8000_0000;
	localparam logic [AD_W-1:0]  AGENT_ADDR_BASE  = 32'h4000_0000;
	localparam logic [AD_W-1:0]  ADDR_DECODE_MASK = 32'hF000_0000;

	typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} master_state_t;
	typedef enum logic {T_IDLE, T_DATA} target_state_t;
endpackage : pci_sec_pkg

//--- pci_sec_if.sv
//----------------------------------------------------------------------
// Purpose : Wires of one secondary bus between bridge end and agent end
// Assumes : Each end drives value plus enable; lines idle high
// Notes   : Resolution stands here so design files hold no float
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface pci_sec_if
	import pci_sec_pkg::*;
#(
	parameter int NREQ = NREQ_BUS_A
);
	logic [AD_W-1:0]  d_ad, h_ad, ad;
	logic [CBE_W-1:0] d_cbe, h_cbe, cbe;
	logic             d_ad_oe, h_ad_oe;
	logic             d_par, h_par, d_par_oe, h_par_oe, par;
	logic [CTL_W-1:0] d_ctl, d_ctl_oe, h_ctl, h_ctl_oe, ctl;
	logic             h_serr_o, h_serr_oe, serr_n;
	logic             rst_n;
	logic [NREQ-1:0]  req_n, gnt_n;

	//--------------------------------------------------
	// Wire resolution, pull-ups on undriven lines
	//--------------------------------------------------
	assign ad     = d_ad_oe ? d_ad : (h_ad_oe ? h_ad : '1);
	assign cbe    = d_ad_oe ? d_cbe : (h_ad_oe ? h_cbe : '1);
	assign par    = d_par_oe ? d_par : (h_par_oe ? h_par : 1'b1);
	assign ctl    = (d_ctl_oe & d_ctl) | (~d_ctl_oe & h_ctl_oe & h_ctl) | (~d_ctl_oe & ~h_ctl_oe);
	assign serr_n = ~(h_serr_oe & ~h_serr_o);

	modport device (
		input  ad, cbe, par, ctl, serr_n, req_n,
		output d_ad, d_cbe, d_ad_oe, d_par, d_par_oe, d_ctl, d_ctl_oe, gnt_n, rst_n
	);
	modport host (
		input  ad, cbe, par, ctl, serr_n, gnt_n, rst_n,
		output h_ad, h_cbe, h_ad_oe, h_par, h_par_oe, h_ctl, h_ctl_oe, h_serr_o, h_serr_oe, req_n
	);
endinterface : pci_sec_if

//--- pci_sec_bridge_end.sv
//----------------------------------------------------------------------
// Purpose : Bridge end of one secondary bus: master, target, arbiter
// Assumes : Instantiate once per secondary bus (NREQ 8 or 7)
// Notes   : Master issues single-phase memory writes from a FIFO
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sync_fifo
	import pci_sec_pkg::*;
#(
	parameter int W     = 64,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic         ce_in,
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr;
	logic [AW:0]   count;
	wire           push       = in_valid_in & in_ready_out;
	wire           pop        = out_ready_in & out_valid_out;
	wire [AW:0]    next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			count        <= '0;
			in_ready_out <= 1'b1;
		end
		else if (ce_in)
		begin
			wr_ptr       <= wr_ptr + AW'(push);
			rd_ptr       <= rd_ptr + AW'(pop);
			count        <= next_count;
			in_ready_out <= (next_count != (AW+1)'(DEPTH));
		end
	end

	// Storage has no reset: only words counted as valid are read
	always_ff @(posedge clk_in)
	begin
		if (ce_in && push)
			mem[wr_ptr] <= in_data_in;
	end
endmodule : sync_fifo

module pci_sec_bridge_end
	import pci_sec_pkg::*;
#(
	parameter int              NREQ      = NREQ_BUS_A,
	parameter logic [AD_W-1:0] ADDR_BASE = DEV_ADDR_BASE,
	parameter logic [AD_W-1:0] ADDR_MASK = ADDR_DECODE_MASK,
	parameter int              DEPTH     = FIFO_DEPTH
)
(
	input  wire logic            clk_in,
	input  wire logic            rstn_in,
	input  wire logic            ce_in,
	input  wire logic            cfg_sec_reset_in,
	input  wire logic            sec_bus_output_allow_in,
	input  wire logic            sec_bus_fast_capable_in,
	input  wire logic            upstream_fast_capable_in,
	input  wire logic            internal_arbiter_select_n_in,
	input  wire logic            tx_valid_in,
	input  wire logic [AD_W-1:0] tx_addr_in,
	input  wire logic [AD_W-1:0] tx_data_in,
	input  wire logic            tx_lock_in,
	output logic                 tx_ready_out,
	input  wire logic            rx_hold_in,
	output logic                 rx_valid_out,
	output logic [AD_W-1:0]      rx_data_out,
	output logic                 master_abort_out,
	output logic                 parity_error_out,
	output logic                 sys_error_out,
	output logic                 fast_mode_out,
	pci_sec_if.device            bus
);
	localparam int             IW   = $clog2(NREQ + 1);
	localparam logic [IW-1:0]  SELF = IW'(NREQ);

	master_state_t    m_state, next_m;
	target_state_t    t_state, next_t;
	logic [CTL_W-1:0] drv, next_drv, ctl_oe;
	logic [AD_W-1:0]  ad_q, next_ad;
	logic [CBE_W-1:0] cbe_q, next_cbe;
	logic             ad_oe, next_ad_oe, par_q, par_oe;
	logic [2:0]       cnt, next_cnt;
	logic             idle_q, chk_pend, chk_par, pop, abort, got;
	logic             bus_rst_n, gnt_on, used, dev_gnt_q;
	logic [1:0]       gap;
	logic [IW-1:0]    gnt_idx;
	logic [NREQ-1:0]  gnt_n_q;
	logic             fifo_valid;
	logic [2*AD_W-1:0] fifo_word;

	//--------------------------------------------------
	// Bus decode
	//--------------------------------------------------
	wire            in_rst    = ~bus_rst_n;
	wire            ext_arb   = internal_arbiter_select_n_in;
	wire            frame_on  = ~bus.ctl[C_FRAME];
	wire            irdy_on   = ~bus.ctl[C_IRDY];
	wire            trdy_on   = ~bus.ctl[C_TRDY];
	wire            devsel_on = ~bus.ctl[C_DEVSEL];
	wire            stop_on   = ~bus.ctl[C_STOP];
	wire            xfer      = irdy_on & trdy_on;
	wire            idle      = ~frame_on & ~irdy_on;
	wire            hit       = ((bus.ad & ADDR_MASK) == ADDR_BASE) && (bus.cbe == CMD_MEM_WRITE);
	wire [NREQ:0]   reqs      = {fifo_valid, ~bus.req_n};
	wire [NREQ:0]   gnt_vec   = gnt_on ? ((NREQ+1)'(1) << gnt_idx) : '0;
	wire            others    = |(reqs & ~((NREQ+1)'(1) << gnt_idx));
	wire            dev_gnt   = ext_arb ? ~bus.req_n[0] : dev_gnt_q;
	wire            allow     = sec_bus_output_allow_in;

	sync_fifo #(.W(2 * AD_W), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.ce_in         (ce_in),
		.in_valid_in   (tx_valid_in),
		.in_data_in    ({tx_addr_in, tx_data_in}),
		.in_ready_out  (tx_ready_out),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_word),
		.out_ready_in  (pop)
	);

	// Nearest requester after the current owner wins
	function automatic logic [IW-1:0] rr_pick(input logic [NREQ:0] r, input logic [IW-1:0] cur);
		logic [IW-1:0] pick;
		int            k;
		pick = cur;
		for (int i = NREQ; i >= 1; i--)
		begin
			k = (int'(cur) + i) % (NREQ + 1);
			if (r[k])
				pick = IW'(k);
		end
		return pick;
	endfunction : rr_pick

	//--------------------------------------------------
	// Output pins; float is asynchronous on purpose
	//--------------------------------------------------
	assign bus.d_ctl    = ~drv;
	assign bus.d_ctl_oe = ctl_oe & {CTL_W{allow}};
	assign bus.d_ad     = ad_q;
	assign bus.d_cbe    = cbe_q;
	assign bus.d_ad_oe  = ad_oe & allow;
	assign bus.d_par    = par_q;
	assign bus.d_par_oe = par_oe & allow;
	assign bus.gnt_n    = gnt_n_q | {NREQ{~allow}};
	assign bus.rst_n    = bus_rst_n;

	//--------------------------------------------------
	// Reset and status
	//--------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			bus_rst_n     <= 1'b0;
			fast_mode_out <= 1'b0;
			sys_error_out <= 1'b0;
		end
		else if (ce_in)
		begin
			bus_rst_n     <= ~cfg_sec_reset_in;
			fast_mode_out <= sec_bus_fast_capable_in & upstream_fast_capable_in;
			sys_error_out <= ~bus.serr_n;
		end
	end

	//--------------------------------------------------
	// Arbiter
	//--------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			gnt_on    <= 1'b0;
			gnt_idx   <= SELF;
			gap       <= '0;
			used      <= 1'b0;
			gnt_n_q   <= '1;
			dev_gnt_q <= 1'b0;
		end
		else if (ce_in)
		begin
			dev_gnt_q <= gnt_vec[NREQ] & ~ext_arb;
			gnt_n_q   <= ext_arb ? {{(NREQ-1){1'b1}}, ~fifo_valid} : ~gnt_vec[NREQ-1:0];
			if (in_rst)
			begin
				gnt_on  <= 1'b0;
				gnt_idx <= SELF;
				gap     <= '0;
				used    <= 1'b0;
			end
			else if (gap != '0)
				gap <= gap - 2'h1;
			else if (!gnt_on)
			begin
				gnt_on  <= 1'b1;
				gnt_idx <= (|reqs) ? rr_pick(reqs, gnt_idx) : SELF;
				used    <= 1'b0;
			end
			else if (idle && others && (used || !reqs[gnt_idx]))
			begin
				gnt_on <= 1'b0;
				gap    <= GAP_LOAD;
			end
			else if (frame_on)
				used <= 1'b1;
		end
	end

	//--------------------------------------------------
	// Master and target next state
	//--------------------------------------------------
	always_comb
	begin
		next_m     = m_state;
		next_t     = t_state;
		next_drv   = drv;
		next_ad    = ad_q;
		next_cbe   = cbe_q;
		next_ad_oe = 1'b0;
		next_cnt   = cnt;
		pop        = 1'b0;
		abort      = 1'b0;
		got        = 1'b0;
		next_drv[C_PERR] = chk_pend & (chk_par ^ bus.par);
		next_drv[C_LOCK] = tx_lock_in & ((m_state != M_IDLE) | drv[C_LOCK]);
		case (m_state)
			M_IDLE:
			begin
				if (fifo_valid && dev_gnt && idle && t_state == T_IDLE)
				begin
					next_m           = M_ADDR;
					next_drv[C_FRAME] = 1'b1;
					next_ad          = fifo_word[2*AD_W-1:AD_W];
					next_cbe         = CMD_MEM_WRITE;
					next_ad_oe       = 1'b1;
				end
				else if (dev_gnt && idle)
					next_ad_oe = 1'b1;
			end
			M_ADDR:
			begin
				next_m            = M_DATA;
				next_drv[C_FRAME] = 1'b0;
				next_drv[C_IRDY]  = 1'b1;
				next_ad           = fifo_word[AD_W-1:0];
				next_cbe          = BE_ALL;
				next_ad_oe        = 1'b1;
				next_cnt          = 3'h1;
			end
			M_DATA:
			begin
				next_ad_oe = 1'b1;
				next_cnt   = cnt + 3'h1;
				if (trdy_on || stop_on)
				begin
					next_drv[C_IRDY] = 1'b0;
					next_ad_oe       = 1'b0;
					pop              = trdy_on;
					next_m           = M_IDLE;
				end
				else if (!devsel_on && cnt == ABORT_CNT)
				begin
					next_drv[C_IRDY] = 1'b0;
					next_ad_oe       = 1'b0;
					pop              = 1'b1;
					abort            = 1'b1;
					next_m           = M_IDLE;
				end
			end
			default: next_m = M_IDLE;
		endcase
		case (t_state)
			T_IDLE:
			begin
				if (frame_on && idle_q && m_state == M_IDLE && hit)
				begin
					next_t             = T_DATA;
					next_drv[C_DEVSEL] = 1'b1;
					next_drv[C_TRDY]   = ~rx_hold_in;
					next_drv[C_STOP]   = rx_hold_in;
				end
			end
			T_DATA:
			begin
				got = xfer;
				if (!frame_on && (!irdy_on || trdy_on || stop_on))
				begin
					next_t             = T_IDLE;
					next_drv[C_DEVSEL] = 1'b0;
					next_drv[C_TRDY]   = 1'b0;
					next_drv[C_STOP]   = 1'b0;
				end
			end
			default: next_t = T_IDLE;
		endcase
	end

	//--------------------------------------------------
	// Bus engine registers
	//--------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			m_state <= M_IDLE;
			t_state <= T_IDLE;
			drv     <= '0;
			ctl_oe  <= '0;
			ad_q    <= '0;
			cbe_q   <= '0;
			ad_oe   <= 1'b1;
			par_q   <= 1'b0;
			par_oe  <= 1'b1;
			cnt     <= '0;
			idle_q  <= 1'b1;
			chk_pend <= 1'b0;
			chk_par  <= 1'b0;
		end
		else if (ce_in)
		begin
			idle_q <= idle;
			cnt    <= next_cnt;
			if (in_rst)
			begin
				m_state  <= M_IDLE;
				t_state  <= T_IDLE;
				drv      <= '0;
				ctl_oe   <= '0;
				ad_q     <= '0;
				cbe_q    <= '0;
				ad_oe    <= 1'b1;
				par_q    <= 1'b0;
				par_oe   <= 1'b1;
				chk_pend <= 1'b0;
			end
			else
			begin
				m_state  <= next_m;
				t_state  <= next_t;
				drv      <= next_drv;
				ctl_oe   <= next_drv | drv;
				ad_q     <= next_ad;
				cbe_q    <= next_cbe;
				ad_oe    <= next_ad_oe;
				par_q    <= ^{ad_q, cbe_q};
				par_oe   <= ad_oe;
				chk_pend <= got;
				chk_par  <= ^{bus.ad, bus.cbe};
			end
		end
	end

	// Event pulses toward the user side
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rx_valid_out     <= 1'b0;
			rx_data_out      <= '0;
			master_abort_out <= 1'b0;
			parity_error_out <= 1'b0;
		end
		else if (ce_in)
		begin
			rx_valid_out     <= got & ~in_rst;
			master_abort_out <= abort & ~in_rst;
			parity_error_out <= next_drv[C_PERR] & ~in_rst;
			if (got)
				rx_data_out <= bus.ad;
		end
	end
endmodule : pci_sec_bridge_end

//--- pci_sec_agent_end.sv
//----------------------------------------------------------------------
// Purpose : Agent end of one secondary bus: one initiator and target
// Assumes : AGENT index is not 0; bus reset comes from bridge end
// Notes   : May also act as external arbiter for the bridge end
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pci_sec_agent_end
	import pci_sec_pkg::*;
#(
	parameter int              NREQ      = NREQ_BUS_A,
	parameter int              AGENT     = 1,
	parameter logic [AD_W-1:0] ADDR_BASE = AGENT_ADDR_BASE,
	parameter logic [AD_W-1:0] ADDR_MASK = ADDR_DECODE_MASK
)
(
	input  wire logic            clk_in,
	input  wire logic            rstn_in,
	input  wire logic            ce_in,
	input  wire logic            ext_arbiter_in,
	input  wire logic            wr_valid_in,
	input  wire logic [AD_W-1:0] wr_addr_in,
	input  wire logic [AD_W-1:0] wr_data_in,
	output logic                 wr_ready_out,
	output logic                 wr_done_out,
	output logic                 wr_abort_out,
	input  wire logic            retry_in,
	input  wire logic            serr_assert_in,
	output logic                 rx_valid_out,
	output logic [AD_W-1:0]      rx_data_out,
	pci_sec_if.host              bus
);
	master_state_t    m_state, next_m;
	target_state_t    t_state, next_t;
	logic [CTL_W-1:0] drv, next_drv, ctl_oe;
	logic [AD_W-1:0]  ad_q, next_ad, wa, wd;
	logic [CBE_W-1:0] cbe_q, next_cbe;
	logic             ad_oe, next_ad_oe, par_q, par_oe, idle_q, pend, fin, done, abort, got;
	logic [2:0]       cnt, next_cnt;
	logic [NREQ-1:0]  req_n_q;

	wire in_rst    = ~bus.rst_n;
	wire frame_on  = ~bus.ctl[C_FRAME];
	wire irdy_on   = ~bus.ctl[C_IRDY];
	wire trdy_on   = ~bus.ctl[C_TRDY];
	wire devsel_on = ~bus.ctl[C_DEVSEL];
	wire stop_on   = ~bus.ctl[C_STOP];
	wire xfer      = irdy_on & trdy_on;
	wire idle      = ~frame_on & ~irdy_on;
	wire hit       = ((bus.ad & ADDR_MASK) == ADDR_BASE) && (bus.cbe == CMD_MEM_WRITE);
	wire my_gnt    = ext_arbiter_in ? req_n_q[0] : ~bus.gnt_n[AGENT];
	wire take      = wr_valid_in & wr_ready_out;
	wire next_pend = (pend & ~fin) | take;

	assign bus.h_ctl     = ~drv;
	assign bus.h_ctl_oe  = ctl_oe;
	assign bus.h_ad      = ad_q;
	assign bus.h_cbe     = cbe_q;
	assign bus.h_ad_oe   = ad_oe;
	assign bus.h_par     = par_q;
	assign bus.h_par_oe  = par_oe;
	assign bus.h_serr_o  = 1'b0;
	assign bus.req_n     = req_n_q;

	//--------------------------------------------------
	// Initiator and target next state
	//--------------------------------------------------
	always_comb
	begin
		next_m     = m_state;
		next_t     = t_state;
		next_drv   = drv;
		next_ad    = ad_q;
		next_cbe   = cbe_q;
		next_ad_oe = 1'b0;
		next_cnt   = cnt;
		done       = 1'b0;
		abort      = 1'b0;
		got        = 1'b0;
		case (m_state)
			M_IDLE:
			begin
				if (pend && my_gnt && idle && t_state == T_IDLE)
				begin
					next_m            = M_ADDR;
					next_drv[C_FRAME] = 1'b1;
					next_ad           = wa;
					next_cbe          = CMD_MEM_WRITE;
					next_ad_oe        = 1'b1;
				end
			end
			M_ADDR:
			begin
				next_m            = M_DATA;
				next_drv[C_FRAME] = 1'b0;
				next_drv[C_IRDY]  = 1'b1;
				next_ad           = wd;
				next_cbe          = BE_ALL;
				next_ad_oe        = 1'b1;
				next_cnt          = 3'h1;
			end
			M_DATA:
			begin
				next_ad_oe = 1'b1;
				next_cnt   = cnt + 3'h1;
				if (trdy_on || stop_on)
				begin
					next_drv[C_IRDY] = 1'b0;
					next_ad_oe       = 1'b0;
					done             = trdy_on;
					next_m           = M_IDLE;
				end
				else if (!devsel_on && cnt == ABORT_CNT)
				begin
					next_drv[C_IRDY] = 1'b0;
					next_ad_oe       = 1'b0;
					abort            = 1'b1;
					next_m           = M_IDLE;
				end
			end
			default: next_m = M_IDLE;
		endcase
		case (t_state)
			T_IDLE:
			begin
				if (frame_on && idle_q && m_state == M_IDLE && hit)
				begin
					next_t             = T_DATA;
					next_drv[C_DEVSEL] = 1'b1;
					next_drv[C_TRDY]   = ~retry_in;
					next_drv[C_STOP]   = retry_in;
				end
			end
			T_DATA:
			begin
				got = xfer;
				if (!frame_on && (!irdy_on || trdy_on || stop_on))
				begin
					next_t             = T_IDLE;
					next_drv[C_DEVSEL] = 1'b0;
					next_drv[C_TRDY]   = 1'b0;
					next_drv[C_STOP]   = 1'b0;
				end
			end
			default: next_t = T_IDLE;
		endcase
		fin = done | abort;
	end

	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			m_state <= M_IDLE;
			t_state <= T_IDLE;
			drv     <= '0;
			ctl_oe  <= '0;
			ad_q    <= '0;
			cbe_q   <= '0;
			ad_oe   <= 1'b0;
			par_q   <= 1'b0;
			par_oe  <= 1'b0;
			cnt     <= '0;
			idle_q  <= 1'b1;
			pend    <= 1'b0;
			wa      <= '0;
			wd      <= '0;
			req_n_q <= '1;
			bus.h_serr_oe <= 1'b0;
			wr_ready_out  <= 1'b0;
			wr_done_out   <= 1'b0;
			wr_abort_out  <= 1'b0;
			rx_valid_out  <= 1'b0;
			rx_data_out   <= '0;
		end
		else if (ce_in)
		begin
			idle_q        <= idle;
			cnt           <= next_cnt;
			bus.h_serr_oe <= serr_assert_in;
			if (in_rst)
			begin
				m_state      <= M_IDLE;
				t_state      <= T_IDLE;
				drv          <= '0;
				ctl_oe       <= '0;
				ad_oe        <= 1'b0;
				par_oe       <= 1'b0;
				pend         <= 1'b0;
				req_n_q      <= '1;
				wr_ready_out <= 1'b0;
				wr_done_out  <= 1'b0;
				wr_abort_out <= 1'b0;
				rx_valid_out <= 1'b0;
			end
			else
			begin
				m_state      <= next_m;
				t_state      <= next_t;
				drv          <= next_drv;
				ctl_oe       <= next_drv | drv;
				ad_q         <= next_ad;
				cbe_q        <= next_cbe;
				ad_oe        <= next_ad_oe;
				par_q        <= ^{ad_q, cbe_q};
				par_oe       <= ad_oe;
				pend         <= next_pend;
				wr_ready_out <= ~next_pend;
				wr_done_out  <= done;
				wr_abort_out <= abort;
				rx_valid_out <= got;
				if (take)
				begin
					wa <= wr_addr_in;
					wd <= wr_data_in;
				end
				if (got)
					rx_data_out <= bus.ad;
				req_n_q        <= '1;
				req_n_q[AGENT] <= ext_arbiter_in | ~next_pend;
				// As arbiter, lend the bus only while holding no work of its own
				if (ext_arbiter_in)
					req_n_q[0] <= ~(~bus.gnt_n[0] & ~next_pend & (next_m == M_IDLE));
			end
		end
	end
endmodule : pci_sec_agent_end

//--- pci_sec_checker.sv
//----------------------------------------------------------------------
// Purpose : Wire-level checks on one secondary bus
// Assumes : One clock domain, bridge end and agent end on the bus
// Notes   : Resolved lines driven by either end are judged, plus the bridge's own drives
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pci_sec_checker
	import pci_sec_pkg::*;
#(
	parameter int NREQ = NREQ_BUS_A
)
(
	input wire logic              clk_in,
	input wire logic              rstn_in,
	input wire logic [AD_W-1:0]   ad,
	input wire logic [CBE_W-1:0]  cbe,
	input wire logic              par,
	input wire logic [CTL_W-1:0]  ctl,
	input wire logic [CTL_W-1:0]  d_ctl,
	input wire logic [CTL_W-1:0]  d_ctl_oe,
	input wire logic              d_ad_oe,
	input wire logic              d_par_oe,
	input wire logic              rst_n,
	input wire logic [NREQ-1:0]   gnt_n
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	wire logic [AD_W-1:0] region = ad & ADDR_DECODE_MASK;
	wire logic            hit    = (region == DEV_ADDR_BASE || region == AGENT_ADDR_BASE) && cbe == CMD_MEM_WRITE;
	// Frame falling out of an idle bus marks the address phase
	sequence addr_ph;
		$past(ctl[C_FRAME]) && !ctl[C_FRAME] && ctl[C_IRDY];
	endsequence
	a_select_on_claim: assert property (addr_ph ##0 hit |=> !ctl[C_DEVSEL]) else $error("claim without select");
	a_abort_timing: assert property (addr_ph ##0 !hit |=> (!ctl[C_IRDY])[*4] ##[1:3] ctl[C_IRDY]) else $error("abort time");
	a_single_phase: assert property (addr_ph |=> ctl[C_FRAME] && !ctl[C_IRDY]) else $error("frame not last");
	a_reset_zero: assert property (!rst_n |-> d_ctl_oe == '0 && ad == '0 && cbe == '0 && !par) else $error("reset drive");
	a_drive_high_first: assert property (((~d_ctl_oe & $past(d_ctl_oe)) & ~$past(d_ctl)) == '0) else $error("bad release");
	a_even_parity: assert property ($past(d_ad_oe) && d_par_oe |-> par == ^{$past(ad), $past(cbe)}) else $error("parity");
	a_grant_gap: assert property ((gnt_n & ~$past(gnt_n)) != '0 |-> (&gnt_n)[*2]) else $error("grant gap");
	a_one_grant: assert property ($onehot0(~gnt_n)) else $error("two grants");
	c_claim: cover property (addr_ph ##0 hit ##1 !ctl[C_TRDY]);
	c_abort: cover property (addr_ph ##0 !hit);
	c_grant_drop: cover property ((gnt_n & ~$past(gnt_n)) != '0);
endmodule : pci_sec_checker

//--- secondary_pci_bus_interface_test.sv
//----------------------------------------------------------------------
// Purpose : Bridge end against agent end on one bus
// Assumes : Internal arbiter, then agent as external arbiter; bus A request count
// Notes   : No parity fault injection, kept small on purpose
//----------------------------------------------------------------------
`timescale 1ns/1ps
module secondary_pci_bus_interface_test
	import pci_sec_pkg::*;
;
	logic clk_in = 0, rstn_in = 0, cfg_rst = 1, allow = 1, f_a = 0, f_up = 0, hold = 0, serr = 0, lock = 0, ext = 0;
	logic tx_valid = 0, wr_valid = 0, tx_ready, rx_valid, m_abort, sys_err, fast, wr_ready, w_abort, a_valid, p_err;
	logic [AD_W-1:0] tx_addr = '0, tx_data = '0, wr_addr = '0, wr_data = '0, rx_data, a_data, a_q[$], b_q[$];
	int err_total = 0, comparisons = 0, aborts = 0, perrs = 0;
	pci_sec_if #(.NREQ(NREQ_BUS_A)) bus ();
	pci_sec_bridge_end u_pci_sec_bridge_end (.clk_in, .rstn_in, .ce_in(1'b1), .cfg_sec_reset_in(cfg_rst),
		.sec_bus_output_allow_in(allow), .sec_bus_fast_capable_in(f_a), .upstream_fast_capable_in(f_up),
		.internal_arbiter_select_n_in(ext), .tx_valid_in(tx_valid), .tx_addr_in(tx_addr), .tx_data_in(tx_data),
		.tx_lock_in(lock), .tx_ready_out(tx_ready), .rx_hold_in(hold), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.master_abort_out(m_abort), .parity_error_out(p_err), .sys_error_out(sys_err), .fast_mode_out(fast), .bus);
	pci_sec_agent_end u_pci_sec_agent_end (.clk_in, .rstn_in, .ce_in(1'b1), .ext_arbiter_in(ext),
		.wr_valid_in(wr_valid), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .wr_ready_out(wr_ready),
		.wr_done_out(), .wr_abort_out(w_abort), .retry_in(hold), .serr_assert_in(serr),
		.rx_valid_out(a_valid), .rx_data_out(a_data), .bus);
	pci_sec_checker #(.NREQ(NREQ_BUS_A)) u_pci_sec_checker (.clk_in, .rstn_in, .ad(bus.ad), .cbe(bus.cbe),
		.par(bus.par), .ctl(bus.ctl), .d_ctl(bus.d_ctl), .d_ctl_oe(bus.d_ctl_oe), .d_ad_oe(bus.d_ad_oe),
		.d_par_oe(bus.d_par_oe), .rst_n(bus.rst_n), .gnt_n(bus.gnt_n));
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		if (a_valid === 1'b1) a_q.push_back(a_data);
		if (rx_valid === 1'b1) b_q.push_back(rx_data);
		if (m_abort === 1'b1 || w_abort === 1'b1) aborts++;
		if (p_err === 1'b1) perrs++;
	end
	function automatic bit ok(input bit c);
		comparisons++;
		return c;
	endfunction : ok
	task automatic bad(input string m);
		err_total++;
		$display("BAD %0t %s", $time, m);
	endtask : bad
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	task automatic push(input logic [AD_W-1:0] a, input logic [AD_W-1:0] d);
		@(posedge clk_in);
		tx_valid <= 1'b1;
		tx_addr <= a;
		tx_data <= d;
		do @(posedge clk_in); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask : push
	task automatic awrite(input logic [AD_W-1:0] a, input logic [AD_W-1:0] d);
		@(posedge clk_in);
		wr_valid <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		do @(posedge clk_in); while (wr_ready !== 1'b1);
		wr_valid <= 1'b0;
	endtask : awrite
	task automatic final_report;
		$display("Mismatches %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Whole run needs well under this span
	initial
	begin
		cyc(6000);
		bad("timeout");
		final_report();
	end
	initial
	begin
		cyc(3);
		rstn_in <= 1'b1;
		cyc(3);
		if (!ok(bus.rst_n === 1'b0)) bad("bus reset not held");
		// Bus held in reset, so the FIFO fills until it refuses
		for (int i = 0; i < FIFO_DEPTH; i++) push(AGENT_ADDR_BASE + 32'(4 * i), 32'(i) ^ 32'h5A5A_0000);
		cyc(2);
		if (!ok(tx_ready === 1'b0)) bad("full FIFO still ready");
		cfg_rst <= 1'b0;
		cyc(300);
		if (!ok(a_q.size() == FIFO_DEPTH)) bad("word count");
		foreach (a_q[i]) if (!ok(a_q[i] === (32'(i) ^ 32'h5A5A_0000))) bad("word order");
		if (!ok(bus.d_ad_oe === 1'b1 && bus.d_par_oe === 1'b1)) bad("bus not parked");
		allow <= 1'b0;
		#1;
		if (!ok({bus.d_ad_oe, bus.d_par_oe, bus.d_ctl_oe, ~bus.gnt_n} === '0)) bad("outputs not floated");
		cyc(1);
		allow <= 1'b1;
		hold <= 1'b1;
		// Both targets retry, so each master must keep its word
		fork
			awrite(DEV_ADDR_BASE + 32'h10, 32'hA5A5_5A5A);
			push(AGENT_ADDR_BASE + 32'h80, 32'h3C3C_0080);
		join_none
		cyc(40);
		if (!ok(b_q.size() == 0 && a_q.size() == FIFO_DEPTH)) bad("held target took word");
		hold <= 1'b0;
		cyc(40);
		if (!ok(b_q.size() == 1 && b_q[0] === 32'hA5A5_5A5A)) bad("agent write lost");
		if (!ok(a_q.size() == FIFO_DEPTH + 1 && a_q[FIFO_DEPTH] === 32'h3C3C_0080)) bad("retried word lost");
		awrite(32'h1000_0000, 32'h1);
		cyc(20);
		lock <= 1'b1;
		push(32'h2000_0000, 32'h2);
		cyc(20);
		if (!ok(bus.ctl[C_LOCK] === 1'b0)) bad("lock not held");
		lock <= 1'b0;
		if (!ok(aborts == 2)) bad("abort count");
		serr <= 1'b1;
		cyc(4);
		if (!ok(sys_err === 1'b1)) bad("system error unseen");
		serr <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			{f_a, f_up} <= 2'(i);
			cyc(3);
			if (!ok(fast === (i == 3))) bad("speed strap");
		end
		// Agent arbitrates: bridge requests on grant line 0, is granted on request line 0
		ext <= 1'b1;
		push(AGENT_ADDR_BASE + 32'h100, 32'h7E7E_0100);
		cyc(30);
		if (!ok(a_q.size() == FIFO_DEPTH + 2 && a_q[FIFO_DEPTH + 1] === 32'h7E7E_0100)) bad("external grant");
		if (!ok(perrs == 0)) bad("false parity error");
		final_report();
	end
endmodule : secondary_pci_bus_interface_test
